// ===== verilog/rms_defines.vh
// constants for the regulator mode supervisor: offsets, fields, resets, timing
`ifndef RMS_DEFINES_VH
`define RMS_DEFINES_VH

// apb register byte offsets
`define RMS_OFF_CTRL 8'h00
`define RMS_OFF_STATUS 8'h04
`define RMS_OFF_TARGET 8'h08
`define RMS_OFF_HBEAT 8'h0C

// control register fields and reset value
`define RMS_CTRL_CAN_EN 0
`define RMS_CTRL_REMOTE 1
`define RMS_CTRL_RESET 2'h1

// clock and timing figures in their own units
`define RMS_CLK_HZ 125000000
`define RMS_QUAL_S 5
`define RMS_HBEAT_MS 500
`define RMS_BLINK_MS 250
`define RMS_RAMP_US 1000
`define RMS_QUAL_CYC (`RMS_QUAL_S * `RMS_CLK_HZ)
`define RMS_HBEAT_CYC (`RMS_HBEAT_MS * (`RMS_CLK_HZ / 1000))
`define RMS_BLINK_CYC (`RMS_BLINK_MS * (`RMS_CLK_HZ / 1000))
`define RMS_RAMP_CYC (`RMS_RAMP_US * (`RMS_CLK_HZ / 1000000))

// electrical thresholds
`define RMS_IDLE_FREQ_HZ 10'h0C8
`define RMS_NOM_FREQ_HZ 10'h190
`define RMS_TRIP_VOLT 8'h5F
`define RMS_TEMP_LIM_C 8'hA0
`define RMS_EXC_THR_LO 10'h0C8
`define RMS_EXC_THR_HI 10'h190
`define RMS_VOLT_CLOSE 8'h02

// heartbeat frame
`define RMS_HB_ID 11'h70A
`define RMS_HB_BYTE_A 8'h05
`define RMS_HB_BYTE_B 8'h85

`endif

// ===== verilog/rms_supervisor.v
// regulator mode supervisor: mode sequencing, limiting, protection, leds, heartbeat, apb
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`include "rms_defines.vh"

module rms_supervisor #(
  parameter QUAL_CYC = `RMS_QUAL_CYC,
  parameter HBEAT_CYC = `RMS_HBEAT_CYC,
  parameter BLINK_CYC = `RMS_BLINK_CYC,
  parameter RAMP_CYC = `RMS_RAMP_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [9:0] gen_freq,
  input wire [7:0] gen_volt,
  input wire [9:0] exc_current,
  input wire [7:0] volt_setpoint,
  input wire [9:0] underspeed_freq,
  input wire [7:0] temp_sensor_input,
  input wire temp_switch_hot,
  input wire temp_linear_sel,
  input wire temp_disable_link,
  input wire self_excite_link,
  input wire supply_input_pair_ok,
  input wire mode_sw_vph,
  input wire exc_thr_sw_high,
  input wire prot_trip_in,
  input wire can_bus_error,
  input wire hb_ack,
  output reg field_enable_q,
  output reg self_excite_path_q,
  output reg [7:0] volt_target_q,
  output reg [9:0] exc_setpoint_q,
  output reg status_led_red_q,
  output reg status_led_green_q,
  output reg can_led_red_q,
  output reg can_led_green_q,
  output reg hb_req_q,
  output reg [10:0] hb_id_q,
  output reg [7:0] hb_data_q
);

  // mode states
  localparam ST_IDLE = 2'b00;
  localparam ST_BUILD = 2'b01;
  localparam ST_VCTRL = 2'b10;
  localparam ST_XLIM = 2'b11;

  // led colour codes
  localparam LED_OFF = 3'd0;
  localparam LED_GRN_BLINK = 3'd1;
  localparam LED_ORG_BLINK = 3'd2;
  localparam LED_GRN = 3'd3;
  localparam LED_ORG = 3'd4;
  localparam LED_RED_GRN = 3'd5;
  localparam LED_RED = 3'd6;

  localparam SYNC_W = 62;

  // register hit: used by both the read mux and the write path
  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  // one led colour and blink phase into red and green drive
  function [1:0] led_rg;
    input [2:0] code;
    input phase;
    begin
      case (code)
        LED_GRN_BLINK: led_rg = {1'b0, phase};
        LED_ORG_BLINK: led_rg = {phase, phase};
        LED_GRN: led_rg = 2'b01;
        LED_ORG: led_rg = 2'b11;
        LED_RED_GRN: led_rg = {phase, ~phase};
        LED_RED: led_rg = 2'b10;
        default: led_rg = 2'b00;
      endcase
    end
  endfunction

  // pin inputs except can_bus_error and hb_ack pass two flip-flops; first stage is read by the second only
  wire [SYNC_W-1:0] pins_raw;
  reg [SYNC_W-1:0] sync1_q;
  reg [SYNC_W-1:0] sync2_q;
  assign pins_raw = {gen_freq, gen_volt, exc_current, volt_setpoint, underspeed_freq,
    temp_sensor_input, temp_switch_hot, temp_linear_sel, temp_disable_link,
    self_excite_link, supply_input_pair_ok, mode_sw_vph, exc_thr_sw_high, prot_trip_in};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= {SYNC_W{1'b0}};
      sync2_q <= {SYNC_W{1'b0}};
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire [9:0] freq_s = sync2_q[61:52];
  wire [7:0] volt_s = sync2_q[51:44];
  wire [9:0] exc_s = sync2_q[43:34];
  wire [7:0] vset_s = sync2_q[33:26];
  wire [9:0] usf_s = sync2_q[25:16];
  wire [7:0] temp_s = sync2_q[15:8];
  wire tsw_s = sync2_q[7];
  wire tlin_s = sync2_q[6];
  wire tdis_s = sync2_q[5];
  wire se_s = sync2_q[4];
  wire sup_s = sync2_q[3];
  wire vph_s = sync2_q[2];
  wire xhi_s = sync2_q[1];
  wire trip_in_s = sync2_q[0];

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] ctrl_q;
  reg trip_q;
  reg temp_lim_q;
  reg [7:0] ramp_q;
  reg [7:0] tgt;
  reg us_lim;
  reg [31:0] ramp_cnt_q;

  // excitation threshold chosen by the strap switch
  wire [9:0] exc_thr = xhi_s ? `RMS_EXC_THR_HI : `RMS_EXC_THR_LO;
  wire freq_low = (freq_s <= `RMS_IDLE_FREQ_HZ);
  wire temp_hot = ~tdis_s & (tlin_s ? (temp_s > `RMS_TEMP_LIM_C) : tsw_s);

  // qualification timers: exc above, exc below, temperature hot
  wire [2:0] qual_cond = {temp_hot, exc_s < exc_thr, exc_s > exc_thr};
  wire [2:0] qual_done;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_qual
      reg [31:0] cnt_q;
      // counter restarts whenever its condition lapses, so only a steady 5 s counts
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= 32'h00000000;
        end else if (!qual_cond[gi]) begin
          cnt_q <= 32'h00000000;
        end else if (cnt_q != QUAL_CYC) begin
          cnt_q <= cnt_q + 32'h00000001;
        end
      end
      assign qual_done[gi] = (cnt_q == QUAL_CYC);
    end
  endgenerate

  // target voltage: v/hz or underspeed scaling, temperature cut, trip override
  reg [17:0] prod, quo;
  reg [9:0] exc_deg;
  reg [9:0] cut;
  always @* begin
    prod = {10'h000, vset_s} * {8'h00, freq_s};
    quo = prod / (vph_s ? {8'h00, `RMS_NOM_FREQ_HZ} : {8'h00, usf_s});
    us_lim = 1'b0;
    tgt = vset_s;
    exc_deg = {2'b00, temp_s} - {2'b00, `RMS_TEMP_LIM_C};
    cut = exc_deg + {1'b0, exc_deg[9:1]};
    if (vph_s) begin
      if (freq_s < `RMS_NOM_FREQ_HZ) begin
        tgt = quo[7:0];
      end
    end else if (freq_s < usf_s) begin
      us_lim = 1'b1;
      tgt = quo[7:0];
    end
    if (temp_lim_q && tlin_s) begin
      tgt = (cut >= {2'b00, tgt}) ? 8'h00 : tgt - cut[7:0];
    end
    if (trip_q) begin
      tgt = `RMS_TRIP_VOLT;
    end
  end

  wire near_tgt = (volt_s >= tgt) ? (volt_s - tgt <= `RMS_VOLT_CLOSE)
    : (tgt - volt_s <= `RMS_VOLT_CLOSE);
  wire ramp_tick = (ramp_cnt_q == RAMP_CYC - 1);
  wire se_active = se_s & ~sup_s;

  // mode sequencing
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (!freq_low && !se_active) begin
          state_d = ST_BUILD;
        end
      end
      ST_BUILD: begin
        if (ramp_q == tgt && near_tgt) begin
          state_d = ST_VCTRL;
        end
      end
      ST_VCTRL: begin
        if (qual_done[0]) begin
          state_d = ST_XLIM;
        end
      end
      ST_XLIM: begin
        if (qual_done[1]) begin
          state_d = ST_BUILD;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (freq_low || se_active) begin
      state_d = ST_IDLE;
    end
  end

  // state, ramp and latched protection
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      ramp_q <= 8'h00;
      ramp_cnt_q <= 32'h00000000;
      trip_q <= 1'b0;
      temp_lim_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ramp_cnt_q <= ramp_tick ? 32'h00000000 : ramp_cnt_q + 32'h00000001;
      // only a power cycle clears a trip; nothing else writes zero here
      if (trip_in_s || (qual_done[2] && !tlin_s)) begin
        trip_q <= 1'b1;
      end
      temp_lim_q <= qual_done[2] | (temp_lim_q & temp_hot);
      if (state_q == ST_IDLE) begin
        ramp_q <= 8'h00;
      end else if (state_q == ST_XLIM && state_d == ST_BUILD) begin
        ramp_q <= volt_s;
      end else if (state_q != ST_XLIM && ramp_tick) begin
        // slew one volt per tick so the target moves smoothly both ways
        if (ramp_q < tgt) begin
          ramp_q <= ramp_q + 8'h01;
        end else if (ramp_q > tgt) begin
          ramp_q <= ramp_q - 8'h01;
        end
      end
    end
  end

  // status and can led colours with a shared blink phase
  reg [31:0] blink_cnt_q;
  reg blink_q;
  reg [2:0] st_code;
  reg [2:0] can_code;
  always @* begin
    case (state_q)
      ST_IDLE: st_code = LED_GRN_BLINK;
      ST_BUILD: st_code = LED_ORG_BLINK;
      ST_XLIM: st_code = LED_ORG;
      ST_VCTRL: st_code = (temp_lim_q || (us_lim && !vph_s)) ? LED_ORG : LED_GRN;
      default: st_code = LED_OFF;
    endcase
    if (trip_q) begin
      st_code = LED_RED_GRN;
    end
    if (!ctrl_q[`RMS_CTRL_CAN_EN]) begin
      can_code = LED_OFF;
    end else if (can_bus_error) begin
      can_code = LED_RED;
    end else if (ctrl_q[`RMS_CTRL_REMOTE]) begin
      can_code = LED_ORG;
    end else begin
      can_code = LED_GRN;
    end
  end

  // outputs toward the field stage and the leds
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_q <= 32'h00000000;
      blink_q <= 1'b0;
      field_enable_q <= 1'b0;
      self_excite_path_q <= 1'b0;
      volt_target_q <= 8'h00;
      exc_setpoint_q <= 10'h000;
      status_led_red_q <= 1'b0;
      status_led_green_q <= 1'b0;
      can_led_red_q <= 1'b0;
      can_led_green_q <= 1'b0;
    end else begin
      if (blink_cnt_q == BLINK_CYC - 1) begin
        blink_cnt_q <= 32'h00000000;
        blink_q <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 32'h00000001;
      end
      field_enable_q <= (state_q != ST_IDLE);
      self_excite_path_q <= se_active;
      volt_target_q <= (state_q == ST_IDLE) ? 8'h00 : (trip_q ? `RMS_TRIP_VOLT : ramp_q);
      exc_setpoint_q <= (state_q == ST_XLIM) ? exc_thr : 10'h3FF;
      {status_led_red_q, status_led_green_q} <= led_rg(st_code, blink_q);
      {can_led_red_q, can_led_green_q} <= led_rg(can_code, blink_q);
    end
  end

  // heartbeat request toward the can controller, held until acknowledged
  reg [31:0] hb_cnt_q;
  reg [15:0] hb_sent_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_cnt_q <= 32'h00000000;
      hb_req_q <= 1'b0;
      hb_id_q <= `RMS_HB_ID;
      hb_data_q <= `RMS_HB_BYTE_A;
      hb_sent_q <= 16'h0000;
    end else begin
      // period timer runs free so a slow ack does not stretch the interval
      if (hb_cnt_q == HBEAT_CYC - 1) begin
        hb_cnt_q <= 32'h00000000;
        hb_req_q <= 1'b1;
      end else begin
        hb_cnt_q <= hb_cnt_q + 32'h00000001;
        if (hb_req_q && hb_ack) begin
          hb_req_q <= 1'b0;
        end
      end
      if (hb_req_q && hb_ack) begin
        hb_sent_q <= hb_sent_q + 16'h0001;
        hb_data_q <= (hb_data_q == `RMS_HB_BYTE_A) ? `RMS_HB_BYTE_B : `RMS_HB_BYTE_A;
      end
    end
  end

  // apb slave: one wait state, pready pulses for one cycle per access
  wire acc = psel & penable & ~pready;
  wire known = hit(paddr, `RMS_OFF_CTRL) | hit(paddr, `RMS_OFF_STATUS)
    | hit(paddr, `RMS_OFF_TARGET) | hit(paddr, `RMS_OFF_HBEAT);
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    if (hit(paddr, `RMS_OFF_CTRL)) begin
      rd_d = {30'h00000000, ctrl_q};
    end else if (hit(paddr, `RMS_OFF_STATUS)) begin
      rd_d = {25'h0000000, field_enable_q, self_excite_path_q, trip_q, us_lim,
        temp_lim_q, state_q};
    end else if (hit(paddr, `RMS_OFF_TARGET)) begin
      rd_d = {14'h0000, exc_setpoint_q, volt_target_q};
    end else if (hit(paddr, `RMS_OFF_HBEAT)) begin
      rd_d = {8'h00, hb_sent_q, hb_data_q};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      ctrl_q <= `RMS_CTRL_RESET;
    end else begin
      pready <= acc;
      pslverr <= acc & ~known;
      prdata <= (acc && !pwrite) ? rd_d : 32'h00000000;
      // write lands on the same edge at which the master sees pready
      if (psel && penable && pready && pwrite && hit(paddr, `RMS_OFF_CTRL)) begin
        ctrl_q <= pwdata[1:0];
      end
    end
  end

endmodule // rms_supervisor

// ===== verification/rms_supervisor_asserts.sv
// port checker for the regulator mode supervisor
`timescale 1ns/100ps
module rms_supervisor_asserts (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [9:0] gen_freq,
  input wire can_bus_error,
  input wire hb_ack,
  input wire field_enable_q,
  input wire can_led_red_q,
  input wire can_led_green_q,
  input wire hb_req_q,
  input wire [10:0] hb_id_q,
  input wire [7:0] hb_data_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answer is a single pulse one cycle after the access phase
  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer late or long");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("error without ready");
  // sync, state and field registers delay four cycles, so five slow samples are just enough
  a_idle_field: assert property ((gen_freq <= 10'h0C8)[*5] |-> !field_enable_q)
    else $error("field on at low frequency");
  a_can_red: assert property (can_led_red_q && !can_led_green_q |-> $past(can_bus_error))
    else $error("can red without error");
  a_can_green: assert property (can_led_green_q |-> !$past(can_bus_error))
    else $error("can green during error");
  a_hb_ident: assert property (hb_id_q == 11'h70A)
    else $error("heartbeat id wrong");
  a_hb_toggle: assert property (hb_req_q && hb_ack |=>
    !hb_req_q && hb_data_q == ($past(hb_data_q) ^ 8'h80))
    else $error("heartbeat ack not taken");
  a_hb_values: assert property (hb_data_q == 8'h05 || hb_data_q == 8'h85)
    else $error("heartbeat byte wrong");
  a_hb_spacing: assert property ($rose(hb_req_q) |=> (!$rose(hb_req_q))[*8])
    else $error("heartbeat too soon");
endmodule // rms_supervisor_asserts

bind rms_supervisor rms_supervisor_asserts rms_supervisor_asserts_inst (.*);

// ===== verification/rms_gen_model.sv
// generator and can node stand-in: voltage follows target, heartbeat acked
`timescale 1ns/100ps
module rms_gen_model (
  input wire pclk,
  input wire presetn,
  input wire slow,
  input wire [7:0] volt_target_q,
  input wire hb_req_q,
  output logic [7:0] gen_volt,
  output logic hb_ack
);
  logic [3:0] wait_q;
  // exciter lags one cycle; a busy bus acks late, so slow waits six cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_volt <= 8'h00;
      hb_ack <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      gen_volt <= volt_target_q;
      hb_ack <= 1'b0;
      if (hb_req_q && !hb_ack) begin
        wait_q <= wait_q + 4'h1;
        if (wait_q >= (slow ? 4'h6 : 4'h0)) begin
          hb_ack <= 1'b1;
          wait_q <= 4'h0;
        end
      end
    end
  end
endmodule // rms_gen_model

// ===== verification/test_regulator_mode_supervisor.sv
// self-checking bench for the regulator mode supervisor
`timescale 1ns/100ps
`include "rms_defines.vh"
module test_regulator_mode_supervisor;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic err;
  wire [31:0] prdata;
  wire pready, pslverr, hb_ack, field_enable_q, self_excite_path_q, hb_req_q;
  wire status_led_red_q, status_led_green_q, can_led_red_q, can_led_green_q;
  wire [7:0] gen_volt, volt_target_q, hb_data_q;
  wire [9:0] exc_setpoint_q;
  wire [10:0] hb_id_q;
  logic [9:0] gen_freq = 10'h064, exc_current = 10'h000, underspeed_freq = 10'h12C;
  logic [7:0] volt_setpoint = 8'h64, temp_sensor_input = 8'h14, d;
  logic temp_switch_hot = 0, temp_linear_sel = 1, temp_disable_link = 0;
  logic self_excite_link = 0, supply_input_pair_ok = 1, mode_sw_vph = 0;
  logic exc_thr_sw_high = 0, prot_trip_in = 0, can_bus_error = 0;
  integer fail_count = 0, tests_run = 0, hb_n = 0, hb_p = 0;

  rms_supervisor #(.QUAL_CYC(20), .HBEAT_CYC(50), .BLINK_CYC(4), .RAMP_CYC(2))
    rms_supervisor_inst (.*);
  rms_gen_model rms_gen_model_inst (.*);

  always #4 pclk = ~pclk;

  task complete_run;
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask

  // request held until pready is sampled, then released for one cycle
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    integer n;
    n = 0;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
    chk("pready", n < 20, 1);
    if (n >= 20) complete_run;
  endtask

  // state polling goes through the status register, bounded
  task wait_st(input logic [1:0] s);
    integer n;
    n = 0;
    do begin
      apb(0, `RMS_OFF_STATUS, 0);
      n++;
    end while (rd[1:0] !== s && n < 150);
    chk("state", rd[1:0], s);
    if (n >= 150) complete_run;
  endtask

  task wait_hb(input logic v);
    integer n;
    n = 0;
    while (hb_req_q !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    hb_n = n;
    chk("hb_wait", n < 200, 1);
    if (n >= 200) complete_run;
  endtask

  task leds(input logic r, input logic g);
    chk("led_red", status_led_red_q, r);
    chk("led_green", status_led_green_q, g);
  endtask

  task t_regs;
    apb(0, `RMS_OFF_CTRL, 0);
    chk("ctrl", rd, `RMS_CTRL_RESET);
    chk("can_g", {can_led_red_q, can_led_green_q}, 2'h1);
    apb(1, `RMS_OFF_CTRL, 3);
    cyc(2);
    chk("can_o", {can_led_red_q, can_led_green_q}, 2'h3);
    can_bus_error <= 1;
    cyc(3);
    chk("can_r", {can_led_red_q, can_led_green_q}, 2'h2);
    apb(1, `RMS_OFF_CTRL, 0);
    cyc(2);
    chk("can_off", {can_led_red_q, can_led_green_q}, 2'h0);
    can_bus_error <= 0;
    apb(1, `RMS_OFF_CTRL, 1);
    apb(0, 8'h10, 0);
    chk("slverr", err, 1);
    chk("bad_rd", rd, 0);
  endtask

  task t_build;
    chk("idle_fld", field_enable_q, 0);
    chk("idle_tgt", volt_target_q, 0);
    gen_freq <= 10'h190;
    cyc(8);
    chk("bld_fld", field_enable_q, 1);
    wait_st(2);
    chk("cv_tgt", volt_target_q, 100);
    leds(0, 1);
    mode_sw_vph <= 1;
    gen_freq <= 10'h12C;
    cyc(90);
    chk("vph_tgt", volt_target_q, 75);
    mode_sw_vph <= 0;
    gen_freq <= 10'h0FA;
    cyc(90);
    chk("us_tgt", volt_target_q, 83);
    leds(1, 1);
    mode_sw_vph <= 1;
    cyc(90);
    chk("us_vph", status_led_red_q, 0);
    mode_sw_vph <= 0;
    gen_freq <= 10'h190;
    wait_st(2);
  endtask

  task t_limits;
    cyc(90);
    chk("us_back", volt_target_q, 100);
    exc_current <= 10'h0FA;
    cyc(8);
    apb(0, `RMS_OFF_STATUS, 0);
    chk("exc_early", rd[1:0], 2);
    wait_st(3);
    chk("exc_sp", exc_setpoint_q, `RMS_EXC_THR_LO);
    leds(1, 1);
    exc_current <= 10'h064;
    wait_st(2);
    cyc(90);
    leds(0, 1);
    temp_sensor_input <= 8'hAA;
    cyc(10);
    chk("tmp_early", volt_target_q, 100);
    cyc(120);
    chk("tmp_tgt", volt_target_q, 85);
    leds(1, 1);
    temp_sensor_input <= 8'h14;
    cyc(90);
    chk("tmp_back", volt_target_q, 100);
  endtask

  task t_hb;
    slow <= 1;
    wait_hb(1);
    d = hb_data_q;
    chk("hb_id", hb_id_q, `RMS_HB_ID);
    wait_hb(0);
    hb_p = hb_n;
    wait_hb(1);
    chk("hb_alt", hb_data_q, d ^ 8'h80);
    chk("hb_period", hb_p + hb_n, 50);
    slow <= 0;
  endtask

  task t_stop;
    gen_freq <= 10'h064;
    cyc(6);
    chk("drop_fld", field_enable_q, 0);
    chk("drop_tgt", volt_target_q, 0);
    wait_st(0);
    gen_freq <= 10'h190;
    prot_trip_in <= 1;
    cyc(8);
    chk("trip_tgt", volt_target_q, `RMS_TRIP_VOLT);
    apb(0, `RMS_OFF_STATUS, 0);
    chk("trip_bit", rd[4], 1);
    prot_trip_in <= 0;
    cyc(300);
    chk("trip_hold", volt_target_q, `RMS_TRIP_VOLT);
  endtask

  // power cycle clears the trip, then self excitation and the switch sensor
  task t_restart;
    presetn <= 0;
    self_excite_link <= 1;
    supply_input_pair_ok <= 0;
    temp_linear_sel <= 0;
    temp_switch_hot <= 1;
    temp_disable_link <= 1;
    cyc(4);
    presetn <= 1;
    cyc(8);
    chk("se_path", self_excite_path_q, 1);
    chk("se_field", field_enable_q, 0);
    supply_input_pair_ok <= 1;
    cyc(8);
    chk("se_off", self_excite_path_q, 0);
    chk("se_build", field_enable_q, 1);
    self_excite_link <= 0;
    cyc(60);
    apb(0, `RMS_OFF_STATUS, 0);
    chk("trip_clr", rd[4], 0);
    chk("tdis_lim", rd[2], 0);
    temp_disable_link <= 0;
    cyc(40);
    apb(0, `RMS_OFF_STATUS, 0);
    chk("tsw_trip", rd[4], 1);
    chk("tsw_lim", rd[2], 1);
    chk("tsw_tgt", volt_target_q, `RMS_TRIP_VOLT);
  endtask

  // reset held for sixteen cycles, then the scenarios in turn
  initial begin
    cyc(16);
    presetn <= 1;
    cyc(1);
    t_regs;
    t_build;
    t_limits;
    t_hb;
    t_stop;
    t_restart;
    complete_run;
  end
endmodule // test_regulator_mode_supervisor
